// [src/bitops_defs.svh]
// constants for the bit and accumulator execution unit
`ifndef BITOPS_DEFS_SVH
`define BITOPS_DEFS_SVH

// ==========================================================
// cycle counts, figures as executed
`define CYC_LOAD_MEM 5'h05
`define CYC_LOAD_IO 5'h04
`define CYC_STORE_MEM 5'h07
`define CYC_STORE_IO 5'h06
`define CYC_FORCE 5'h07
`define CYC_BR_MEM_TAKEN 5'h08
`define CYC_BR_MEM_FALL 5'h07
`define CYC_BR_IO_TAKEN 5'h07
`define CYC_BR_IO_FALL 5'h06
`define CYC_TAS_TAKEN 5'h0a
`define CYC_TAS_FALL 5'h09
`define CYC_BYTE_EXCH 5'h03
`define CYC_WORD_EXCH 5'h02
`define CYC_BYTE_EXT 5'h01
`define CYC_WORD_SEXT 5'h02
`define CYC_WORD_ZERO_EXT 5'h01

// ==========================================================
// accumulator reset value and counter step
`define ACC_RESET 32'h0000_0000
`define CNT_ONE 5'h01

`endif

// [src/bitops_pkg.sv]
// types for the bit and accumulator execution unit
package bitops_pkg;

    // ==========================================================
    // instruction kinds
    typedef enum logic [3:0] {
        op_bit_load, op_bit_store, bit_force_one, bit_force_zero,
        branch_on_bit_low, branch_on_bit_high, test_and_set_branch,
        wait_bit_high, wait_bit_low, acc_byte_exchange, acc_word_exchange,
        byte_sign_extend, word_sign_extend, byte_zero_extend, word_zero_extend
    } op_e;

    typedef enum logic [1:0] {
        direct_page_bit_operand, absolute_bit_operand, io_area_bit_operand
    } form_e;

    // gray path idle -> read -> data -> run
    typedef enum logic [2:0] {
        st_idle = 3'h0, st_read = 3'h1, st_data = 3'h3, st_run = 3'h2
    } state_e;

    // ==========================================================
    // carriers
    typedef struct packed {
        op_e op;
        form_e form;
        logic [23:0] addr;
        logic [2:0] bit_pos;
    } instr_s;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [23:0] addr;
        logic [7:0] wdata;
    } bus_req_s;

endpackage : bitops_pkg

// [src/cpu_bit_and_acc_ops.sv]
// execution unit for bit manipulation and accumulator manipulation
// Function
// - bit load direct page: bit to low word, old low to high, n z, 5 cycles
// - bit load absolute operand behaves alike, 5 cycles
// - bit load io operand behaves alike, 4 cycles
// - bit store writes accumulator bit by read-modify-write, sets n z, 7 cycles, 6 for io operand
// - force one sets bit by read-modify-write, no flags, 7 cycles
// - force zero clears bit by read-modify-write, no flags, 7 cycles
// - branch on bit low branches when bit is zero, z from bit
// - branch on bit high branches when bit is one, z from bit
// - direct or absolute bit branches take 8 taken, 7 not taken
// - io bit branches take 7 taken, 6 not taken
// - test and set branches on one, leaves bit one, z from bit
// - test and set takes 10 cycles when taken, 9 otherwise
// - wait bit high polls io bit until one, flags untouched
// - wait bit low polls io bit until zero, flags untouched
// - bit waits have no timeout, polling continues while unmet
// - byte exchange swaps low two bytes in 3 cycles, no flags
// - word exchange swaps accumulator halves in 2 cycles, no flags
`timescale 1ns/10ps
`include "bitops_defs.svh"

module cpu_bit_and_acc_ops (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic start,
    input wire bitops_pkg::instr_s instr,
    input wire logic [7:0] rdata,
    input wire logic acc_load,
    input wire logic [31:0] acc_wdata,
    output bitops_pkg::bus_req_s bus,
    output logic busy,
    output logic done,
    output logic branch_taken,
    output logic [31:0] acc,
    output logic flag_n,
    output logic flag_z
);
    import bitops_pkg::*;

    // ==========================================================
    // reset release
    logic [1:0] rst_sync;
    logic rst_n;

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    // ==========================================================
    // decode helpers
    function automatic logic is_mem(input op_e op);
        is_mem = (op inside {op_bit_load, op_bit_store, bit_force_one, bit_force_zero,
            branch_on_bit_low, branch_on_bit_high, test_and_set_branch,
            wait_bit_high, wait_bit_low});
    endfunction : is_mem

    function automatic logic [4:0] cycles(input op_e op, input form_e form,
                                          input logic taken);
        logic io;
        io = (form == io_area_bit_operand);
        case (op)
            op_bit_load: cycles = io ? `CYC_LOAD_IO : `CYC_LOAD_MEM;
            op_bit_store: cycles = io ? `CYC_STORE_IO : `CYC_STORE_MEM;
            bit_force_one, bit_force_zero: cycles = `CYC_FORCE;
            branch_on_bit_low, branch_on_bit_high: begin
                if (io) begin
                    cycles = taken ? `CYC_BR_IO_TAKEN : `CYC_BR_IO_FALL;
                end else begin
                    cycles = taken ? `CYC_BR_MEM_TAKEN : `CYC_BR_MEM_FALL;
                end
            end
            test_and_set_branch: cycles = taken ? `CYC_TAS_TAKEN : `CYC_TAS_FALL;
            acc_byte_exchange: cycles = `CYC_BYTE_EXCH;
            acc_word_exchange: cycles = `CYC_WORD_EXCH;
            word_sign_extend: cycles = `CYC_WORD_SEXT;
            word_zero_extend: cycles = `CYC_WORD_ZERO_EXT;
            default: cycles = `CYC_BYTE_EXT;
        endcase
    endfunction : cycles

    // result of a register-only op as {n, z, acc}
    function automatic logic [33:0] acc_op(input op_e op, input logic [31:0] a,
                                           input logic n, input logic z);
        logic [31:0] r;
        r = a;
        case (op)
            acc_byte_exchange: acc_op = {n, z, a[31:16], a[7:0], a[15:8]};
            acc_word_exchange: acc_op = {n, z, a[15:0], a[31:16]};
            byte_sign_extend: begin
                r = {a[31:16], {8{a[7]}}, a[7:0]};
                acc_op = {a[7], (r[15:0] == 16'h0000), r};
            end
            word_sign_extend: begin
                r = {{16{a[15]}}, a[15:0]};
                acc_op = {a[15], (r == 32'h0000_0000), r};
            end
            byte_zero_extend: begin
                r = {a[31:16], 8'h00, a[7:0]};
                acc_op = {1'b0, (r[15:0] == 16'h0000), r};
            end
            word_zero_extend: begin
                r = {16'h0000, a[15:0]};
                acc_op = {1'b0, (r == 32'h0000_0000), r};
            end
            default: acc_op = {n, z, a};
        endcase
    endfunction : acc_op

    // ==========================================================
    // execution state
    state_e state, next_state;
    instr_s cur, next_cur;
    logic [7:0] data, next_data;
    logic [4:0] cnt, next_cnt;
    bus_req_s next_bus;
    logic next_busy, next_done, next_branch_taken;
    logic [31:0] next_acc;
    logic next_flag_n, next_flag_z;
    op_e op_sel;
    logic bit_val, taken;
    logic [4:0] total;
    logic [7:0] mod_byte;
    logic [33:0] reg_res;

    always_comb begin
        next_state = state;
        next_cur = cur;
        next_data = data;
        next_cnt = cnt;
        next_bus = bus;
        next_bus.rd = 1'b0;
        next_bus.wr = 1'b0;
        next_busy = busy;
        next_done = 1'b0;
        next_branch_taken = branch_taken;
        next_acc = acc;
        next_flag_n = flag_n;
        next_flag_z = flag_z;
        op_sel = (state == st_idle) ? instr.op : cur.op;
        reg_res = acc_op(op_sel, acc, flag_n, flag_z);
        bit_val = data[cur.bit_pos];
        case (cur.op)
            branch_on_bit_low: taken = !bit_val;
            branch_on_bit_high, test_and_set_branch: taken = bit_val;
            default: taken = 1'b0;
        endcase
        total = cycles(cur.op, cur.form, taken);
        mod_byte = data;
        case (cur.op)
            op_bit_store: mod_byte[cur.bit_pos] = acc[0];
            bit_force_zero: mod_byte[cur.bit_pos] = 1'b0;
            default: mod_byte[cur.bit_pos] = 1'b1;
        endcase
        case (state)
            st_idle: begin
                if (start) begin
                    next_cur = instr;
                    next_cnt = `CNT_ONE;
                    next_busy = 1'b1;
                    next_branch_taken = 1'b0;
                    if (is_mem(instr.op)) begin
                        next_bus.rd = 1'b1;
                        next_bus.addr = instr.addr;
                        next_state = st_read;
                    end else if (cycles(instr.op, instr.form, 1'b0) == `CNT_ONE) begin
                        // single-cycle ops retire straight from idle
                        {next_flag_n, next_flag_z, next_acc} = reg_res;
                        next_done = 1'b1;
                        next_busy = 1'b0;
                    end else begin
                        next_state = st_run;
                    end
                end else if (acc_load) begin
                    next_acc = acc_wdata;
                end
            end
            st_read: begin
                next_cnt = cnt + `CNT_ONE;
                next_state = st_data;
            end
            st_data: begin
                next_data = rdata;
                next_cnt = cnt + `CNT_ONE;
                if (cur.op == wait_bit_high || cur.op == wait_bit_low) begin
                    // polls forever while unmet, a stuck bit hangs the unit
                    if (rdata[cur.bit_pos] == (cur.op == wait_bit_high)) begin
                        next_done = 1'b1;
                        next_busy = 1'b0;
                        next_state = st_idle;
                    end else begin
                        next_bus.rd = 1'b1;
                        next_state = st_read;
                    end
                end else begin
                    next_state = st_run;
                end
            end
            st_run: begin
                next_cnt = cnt + `CNT_ONE;
                if (is_mem(cur.op) && cnt == total - 5'h02
                    && cur.op inside {op_bit_store, bit_force_one, bit_force_zero,
                                      test_and_set_branch}) begin
                    next_bus.wr = 1'b1;
                    next_bus.wdata = mod_byte;
                end
                if (cnt == total - `CNT_ONE) begin
                    next_done = 1'b1;
                    next_busy = 1'b0;
                    next_state = st_idle;
                    next_branch_taken = taken;
                    case (cur.op)
                        op_bit_load: begin
                            next_acc = {acc[15:0], 15'h0000, bit_val};
                            next_flag_n = 1'b0;
                            next_flag_z = !bit_val;
                        end
                        op_bit_store: begin
                            next_flag_n = 1'b0;
                            next_flag_z = !acc[0];
                        end
                        branch_on_bit_low, branch_on_bit_high, test_and_set_branch: begin
                            next_flag_z = !bit_val;
                        end
                        bit_force_one, bit_force_zero: next_flag_z = flag_z;
                        default: begin
                            {next_flag_n, next_flag_z, next_acc} = reg_res;
                        end
                    endcase
                end
            end
            default: begin
                next_state = st_idle;
                next_busy = 1'b0;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state <= st_idle;
            cur <= '0;
            data <= 8'h00;
            cnt <= 5'h00;
            bus <= '0;
            busy <= 1'b0;
            done <= 1'b0;
            branch_taken <= 1'b0;
            acc <= `ACC_RESET;
            flag_n <= 1'b0;
            flag_z <= 1'b0;
        end else begin
            state <= next_state;
            cur <= next_cur;
            data <= next_data;
            cnt <= next_cnt;
            bus <= next_bus;
            busy <= next_busy;
            done <= next_done;
            branch_taken <= next_branch_taken;
            acc <= next_acc;
            flag_n <= next_flag_n;
            flag_z <= next_flag_z;
        end
    end

    // ==========================================================
    // checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    logic go;
    assign go = start && !busy;
    a_load_mem_time: assert property (go && instr.op == op_bit_load
        && instr.form != io_area_bit_operand |-> ##5 done)
        else $error("bit load timing wrong");
    a_load_io_time: assert property (go && instr.op == op_bit_load
        && instr.form == io_area_bit_operand |-> ##4 (done && !flag_n))
        else $error("io bit load timing wrong");
    a_store_rmw_seq: assert property (go && instr.op == op_bit_store
        && instr.form == direct_page_bit_operand |-> ##1 bus.rd ##5 bus.wr ##1 done)
        else $error("bit store sequence wrong");
    a_force_one_data: assert property (bus.wr && cur.op == bit_force_one
        |-> bus.wdata[cur.bit_pos] && $stable(flag_z))
        else $error("force one wrote zero");
    a_force_zero_data: assert property (bus.wr && cur.op == bit_force_zero
        |-> !bus.wdata[cur.bit_pos])
        else $error("force zero wrote one");
    a_branch_low_cond: assert property (done && cur.op == branch_on_bit_low
        |-> branch_taken == !data[cur.bit_pos] && flag_z == !data[cur.bit_pos])
        else $error("branch on low wrong");
    a_branch_high_cond: assert property (done && cur.op == branch_on_bit_high
        |-> branch_taken == data[cur.bit_pos] && !bus.wr)
        else $error("branch on high wrong");
    a_branch_mem_time: assert property (go
        && instr.op inside {branch_on_bit_low, branch_on_bit_high}
        && instr.form != io_area_bit_operand
        |-> ##7 (done && !branch_taken) or ##8 (done && branch_taken))
        else $error("memory bit branch timing wrong");
    a_branch_io_time: assert property (go
        && instr.op inside {branch_on_bit_low, branch_on_bit_high}
        && instr.form == io_area_bit_operand
        |-> ##6 (done && !branch_taken) or ##7 (done && branch_taken))
        else $error("io bit branch timing wrong");
    a_tas_sets_bit: assert property (bus.wr && cur.op == test_and_set_branch
        |-> bus.wdata[cur.bit_pos] ##1 (done && branch_taken == data[cur.bit_pos]))
        else $error("test and set wrong");
    a_tas_time: assert property (go && instr.op == test_and_set_branch
        |-> ##9 (done && !branch_taken) or ##10 (done && branch_taken))
        else $error("test and set timing wrong");
    a_wait_flags_kept: assert property (busy && cur.op inside {wait_bit_high, wait_bit_low}
        |=> $stable(flag_n) && $stable(flag_z))
        else $error("wait changed flags");
    a_wait_retry: assert property (state == st_data && cur.op == wait_bit_high
        && !rdata[cur.bit_pos] |=> bus.rd && !done)
        else $error("wait stopped polling");
    a_byte_exch_acc: assert property (go && instr.op == acc_byte_exchange
        |-> ##3 (done && acc[15:8] == $past(acc[7:0], 3)))
        else $error("byte exchange wrong");
    a_word_exch_acc: assert property (go && instr.op == acc_word_exchange
        |-> ##2 (done && acc[31:16] == $past(acc[15:0], 2)))
        else $error("word exchange wrong");
    a_zero_ext_n: assert property (done && cur.op == byte_zero_extend
        |-> acc[15:8] == 8'h00 && !flag_n)
        else $error("zero extend wrong");
    a_bit_addr_used: assert property (bus.rd |-> bus.addr == cur.addr)
        else $error("bit operand address wrong");
    c_branch_taken: cover property (done && branch_taken && cur.op == branch_on_bit_high);
    c_wait_retry: cover property (bus.rd && cur.op == wait_bit_low && cnt > 5'h03);
    c_tas_done: cover property (done && cur.op == test_and_set_branch);
    c_word_sext: cover property (done && cur.op == word_sign_extend && flag_n);

endmodule : cpu_bit_and_acc_ops

// [tb/mem_model.sv]
// sparse byte memory and io area answering the execution unit's bus
`timescale 1ns/10ps

module mem_model (
    input wire logic mclk,
    input wire bitops_pkg::bus_req_s bus,
    output logic [7:0] rdata
);
    import bitops_pkg::*;

    // ==========================================================
    // storage
    logic [7:0] mem [logic [23:0]];

    // ==========================================================
    // answer exactly one cycle after the read strobe, no wait states;
    // outside that cycle the data toggles so stale bytes never look valid
    always @(posedge mclk) begin
        if (bus.rd) begin
            rdata <= mem.exists(bus.addr) ? mem[bus.addr] : 8'h00;
        end else begin
            rdata <= ~rdata;
        end
        if (bus.wr) begin
            mem[bus.addr] = bus.wdata;
        end
    end
endmodule : mem_model

// [tb/testbench.sv]
// self-checking bench for the bit and accumulator execution unit
`timescale 1ns/10ps

module testbench;
    import bitops_pkg::*;

    logic mclk, reset_n, start, acc_load;
    instr_s instr;
    logic [7:0] rdata;
    logic [31:0] acc_wdata, acc;
    bus_req_s bus;
    logic busy, done, branch_taken, flag_n, flag_z;
    int num_errors = 0;
    int n_checks = 0;
    logic [23:0] addrs [3] = '{24'h000030, 24'h004321, 24'h0000d0};

    cpu_bit_and_acc_ops DUT (.mclk(mclk), .reset_n(reset_n), .start(start), .instr(instr),
        .rdata(rdata), .acc_load(acc_load), .acc_wdata(acc_wdata), .bus(bus), .busy(busy),
        .done(done), .branch_taken(branch_taken), .acc(acc), .flag_n(flag_n), .flag_z(flag_z));
    mem_model mem_i (.mclk(mclk), .bus(bus), .rdata(rdata));

    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    // ==========================================================
    // shared helpers
    task automatic check(input logic ok, input string what);
        n_checks++;
        if (ok !== 1'b1) begin
            num_errors++;
            $display("wrong value at %0t ns: %s", $time, what);
        end
    endtask : check

    task automatic set_acc(input logic [31:0] v);
        acc_wdata = v;
        acc_load = 1'b1;
        @(negedge mclk);
        acc_load = 1'b0;
    endtask : set_acc

    // called at a falling edge; returns the cycle of the done pulse
    task automatic run_op(input op_e op, input form_e f, input logic [23:0] a,
                          input logic [2:0] p, output int n);
        instr = '{op: op, form: f, addr: a, bit_pos: p};
        start = 1'b1;
        @(negedge mclk);
        start = 1'b0;
        n = 1;
        while (done !== 1'b1 && n < 500) begin
            @(negedge mclk);
            n++;
        end
    endtask : run_op

    // ==========================================================
    // scenarios
    task automatic t_load();
        int n;
        mem_i.mem[24'h000010] = 8'h20;
        mem_i.mem[24'h123456] = 8'hef;
        mem_i.mem[24'h0000c4] = 8'h01;
        set_acc(32'h1234_5678);
        run_op(op_bit_load, direct_page_bit_operand, 24'h000010, 3'h5, n);
        check(n == 5, "load direct cycles");
        check(acc === 32'h5678_0001, "load direct acc");
        check({flag_n, flag_z} === 2'b00, "load direct flags");
        run_op(op_bit_load, absolute_bit_operand, 24'h123456, 3'h4, n);
        check(n == 5, "load absolute cycles");
        check(acc === 32'h0001_0000, "load absolute acc");
        check({flag_n, flag_z} === 2'b01, "load absolute flags");
        run_op(op_bit_load, io_area_bit_operand, 24'h0000c4, 3'h0, n);
        check(n == 4, "load io cycles");
        check(acc === 32'h0000_0001, "load io acc");
        $display("load test done");
    endtask : t_load

    task automatic t_store();
        int n;
        mem_i.mem[24'h000020] = 8'h00;
        mem_i.mem[24'h0000c8] = 8'hff;
        set_acc(32'hffff_0001);
        run_op(op_bit_store, direct_page_bit_operand, 24'h000020, 3'h7, n);
        check(n == 7, "store direct cycles");
        check(mem_i.mem[24'h000020] === 8'h80, "store direct byte");
        check({flag_n, flag_z} === 2'b00, "store direct flags");
        set_acc(32'h0000_0000);
        run_op(op_bit_store, io_area_bit_operand, 24'h0000c8, 3'h0, n);
        check(n == 6, "store io cycles");
        check(mem_i.mem[24'h0000c8] === 8'hfe, "store io byte");
        check({flag_n, flag_z} === 2'b01, "store io flags");
        $display("store test done");
    endtask : t_store

    task automatic t_force();
        int n;
        logic [1:0] fl;
        for (int i = 0; i < 3; i++) begin
            fl = {flag_n, flag_z};
            mem_i.mem[addrs[i]] = 8'h00;
            run_op(bit_force_one, form_e'(i), addrs[i], 3'h3, n);
            check(n == 7, "force one cycles");
            check(mem_i.mem[addrs[i]] === 8'h08, "force one byte");
            check({flag_n, flag_z} === fl, "force one flags");
            mem_i.mem[addrs[i]] = 8'hff;
            run_op(bit_force_zero, form_e'(i), addrs[i], 3'h6, n);
            check(n == 7, "force zero cycles");
            check(mem_i.mem[addrs[i]] === 8'hbf, "force zero byte");
            check({flag_n, flag_z} === fl, "force zero flags");
        end
        $display("force test done");
    endtask : t_force

    task automatic t_branch();
        int n;
        int exp_n;
        logic tk;
        logic [7:0] v;
        for (int o = 0; o < 2; o++) begin
            for (int b = 0; b < 2; b++) begin
                for (int i = 0; i < 3; i++) begin
                    v = (b == 1) ? 8'h04 : 8'hfb;
                    mem_i.mem[addrs[i]] = v;
                    tk = ((o == 1) == (b == 1));
                    exp_n = (i == 2) ? (tk ? 7 : 6) : (tk ? 8 : 7);
                    run_op(o == 1 ? branch_on_bit_high : branch_on_bit_low, form_e'(i),
                           addrs[i], 3'h2, n);
                    check(n == exp_n, "branch cycles");
                    check(branch_taken === tk, "branch decision");
                    check(flag_z === (b == 0), "branch zero flag");
                    check(mem_i.mem[addrs[i]] === v, "branch touched memory");
                end
            end
        end
        $display("branch test done");
    endtask : t_branch

    task automatic t_tas();
        int n;
        mem_i.mem[24'h005555] = 8'h02;
        run_op(test_and_set_branch, absolute_bit_operand, 24'h005555, 3'h1, n);
        check(n == 10, "test and set taken cycles");
        check(branch_taken === 1'b1 && flag_z === 1'b0, "test and set taken");
        check(mem_i.mem[24'h005555] === 8'h02, "test and set byte");
        mem_i.mem[24'h005555] = 8'hfd;
        run_op(test_and_set_branch, absolute_bit_operand, 24'h005555, 3'h1, n);
        check(n == 9, "test and set fall cycles");
        check(branch_taken === 1'b0 && flag_z === 1'b1, "test and set fall");
        check(mem_i.mem[24'h005555] === 8'hff, "test and set leaves one");
        $display("test and set test done");
    endtask : t_tas

    // the io bit flips while the unit polls; no count bounds the wait itself
    task automatic t_wait();
        int n;
        logic [1:0] fl;
        fl = {flag_n, flag_z};
        mem_i.mem[24'h0000e0] = 8'h00;
        fork
            run_op(wait_bit_high, io_area_bit_operand, 24'h0000e0, 3'h5, n);
            begin
                repeat (20) @(negedge mclk);
                check(busy === 1'b1, "wait high busy");
                mem_i.mem[24'h0000e0] = 8'h20;
            end
        join
        check(n >= 20 && n <= 24, "wait high cycles");
        check({flag_n, flag_z} === fl, "wait high flags");
        fork
            run_op(wait_bit_low, io_area_bit_operand, 24'h0000e0, 3'h5, n);
            begin
                repeat (30) @(negedge mclk);
                check(busy === 1'b1, "wait low busy");
                mem_i.mem[24'h0000e0] = 8'hdf;
            end
        join
        check(n >= 30 && n <= 34, "wait low cycles");
        check({flag_n, flag_z} === fl, "wait low flags");
        $display("wait test done");
    endtask : t_wait

    task automatic t_acc();
        int n;
        logic [1:0] fl;
        fl = {flag_n, flag_z};
        set_acc(32'h1234_5678);
        run_op(acc_byte_exchange, direct_page_bit_operand, 24'h0, 3'h0, n);
        check(n == 3 && acc === 32'h1234_7856, "byte exchange");
        check({flag_n, flag_z} === fl, "byte exchange flags");
        run_op(acc_word_exchange, direct_page_bit_operand, 24'h0, 3'h0, n);
        check(n == 2 && acc === 32'h7856_1234, "word exchange");
        check({flag_n, flag_z} === fl, "word exchange flags");
        set_acc(32'haaaa_1280);
        run_op(byte_sign_extend, direct_page_bit_operand, 24'h0, 3'h0, n);
        check(n == 1 && acc === 32'haaaa_ff80 && {flag_n, flag_z} === 2'b10, "sext b");
        set_acc(32'h0000_8000);
        run_op(word_sign_extend, direct_page_bit_operand, 24'h0, 3'h0, n);
        check(n == 2 && acc === 32'hffff_8000 && {flag_n, flag_z} === 2'b10, "sext w");
        set_acc(32'h1234_ff00);
        run_op(byte_zero_extend, direct_page_bit_operand, 24'h0, 3'h0, n);
        check(n == 1 && acc === 32'h1234_0000 && {flag_n, flag_z} === 2'b01, "zero b");
        set_acc(32'hffff_0000);
        run_op(word_zero_extend, direct_page_bit_operand, 24'h0, 3'h0, n);
        check(n == 1 && acc === 32'h0 && {flag_n, flag_z} === 2'b01, "zero w");
        $display("accumulator test done");
    endtask : t_acc

    // ==========================================================
    // closing and main sequence
    task automatic finish_test();
        $display("checks %0d, mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : finish_test

    initial begin
        reset_n = 1'b0;
        start = 1'b0;
        acc_load = 1'b0;
        acc_wdata = 32'h0;
        instr = '0;
        repeat (8) @(negedge mclk);
        reset_n = 1'b1;
        repeat (3) @(negedge mclk);
        t_load();
        t_store();
        t_force();
        t_branch();
        t_tas();
        t_wait();
        t_acc();
        finish_test();
    end

    // the whole run needs well under a thousand cycles
    initial begin
        repeat (20000) @(posedge mclk);
        num_errors++;
        $display("wrong value at %0t ns: watchdog expired", $time);
        finish_test();
    end
endmodule : testbench
